// *** rtl/sepc_pkg.sv ***
// constants, states and pin carrier of the serial memory command port
// Summary of operation
// (RL1) start bit, opcode, address, then write data
// (RL2) length set by organisation, extra address bit in byte mode
// (RL3) serial input sampled on serial clock rise
// (RL4) output floats except read data or status
// (RL5) output low while busy, high when ready
// (RL6) dummy one releases output on falling clock
// (RL7) shared data line should be released after polling
// (RL8) read sends dummy zero then word MSB first
// (RL9) read data bits change on rising clock
// (RL10) host deselects after write for minimum low time
// (RL11) select fall after write starts clear-then-store
// (RL12) timed cycle finishes without serial clocks
// (RL13) write clears location itself before storing
// (RL14) host deselects after erase, select fall clears
// (RL15) erased location reads all ones
// (RL16) unused top address bit ignored, host drives it
// (RL17) host waits after power-up before access
// (RL18) 16-bit or 8-bit organisation sets field widths
// (RL19) opcode 11 erases the addressed location
// (RL20) opcode 01 writes, 10 reads, 00 special
// (RL21) programming locked from reset until unlock command
// (RL22) timed cycle ends in program time, then ready
// (RL23) early deselect aborts without touching stored data
package sepc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_EW_US       = 10000;
  // longest time, so the division rounds down
  localparam int PROG_CYCLES   = (T_EW_US * 1000) / CLK_PERIOD_NS;
  localparam int TIMER_W       = 18;

  // ==========================================================
  // instruction fields
  localparam logic [4:0] OPC_BITS     = 5'h02;
  localparam logic [4:0] ADR_BITS_X16 = 5'h08;
  localparam logic [4:0] ADR_BITS_X8  = 5'h09;
  localparam logic [4:0] DAT_BITS_X16 = 5'h10;
  localparam logic [4:0] DAT_BITS_X8  = 5'h08;
  localparam logic [1:0] OPC_SPECIAL  = 2'h0;
  localparam logic [1:0] OPC_WRITE    = 2'h1;
  localparam logic [1:0] OPC_READ     = 2'h2;
  localparam logic [1:0] OPC_ERASE    = 2'h3;
  // special commands, top two address bits
  localparam logic [1:0] SUB_LOCK       = 2'h0;
  localparam logic [1:0] SUB_FILL_ALL   = 2'h1;
  localparam logic [1:0] SUB_CLEAR_ALL  = 2'h2;
  localparam logic [1:0] SUB_UNLOCK     = 2'h3;

  // ==========================================================
  // array
  localparam int         MEM_BYTES   = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] LAST_BYTE   = 8'hFF;

  typedef enum logic [4:0] {
    S_START = 5'h01,
    S_SHIFT = 5'h02,
    S_READ  = 5'h04,
    S_DONE  = 5'h08,
    S_PROG  = 5'h10
  } sepc_state_e;

  typedef struct packed {
    logic cs;
    logic serial_clock_in;
    logic serial_in;
    logic word_width_select;
  } sepc_pins_s;
endpackage

// *** rtl/sepc_port.sv ***
// serial memory command port: decoder, read shifter, timed program cycle
`timescale 1ns/100ps
`default_nettype none
module sepc_port #(
  parameter int PROG_CYCLES_P = sepc_pkg::PROG_CYCLES
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic CS,
  input  wire logic SERIAL_CLOCK_IN,
  input  wire logic SERIAL_IN,
  input  wire logic WORD_WIDTH_SELECT,
  output logic      SERIAL_OUT,
  output logic      SERIAL_OUT_OE_N
);
  import sepc_pkg::*;

  // ==========================================================
  // pin synchroniser
  sepc_pins_s  s1_q;
  sepc_pins_s  s2_q;
  sepc_pins_s  s3_q;
  logic        serial_clock_rise;
  logic        serial_clock_fall;
  logic        cs;
  logic        data_bit;

  // ==========================================================
  // state
  sepc_state_e st_q;
  sepc_state_e st_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic [1:0]  op_q;
  logic [1:0]  op_d;
  logic [8:0]  adr_q;
  logic [8:0]  adr_d;
  logic [15:0] dat_q;
  logic [15:0] dat_d;
  logic        x16_q;
  logic        x16_d;
  logic        unlock_q;
  logic        unlock_d;
  logic        pend_q;
  logic        pend_d;
  logic        status_q;
  logic        status_d;
  logic        dummy_q;
  logic        dummy_d;
  logic        out_q;
  logic        out_d;
  logic        oe_n_q;
  logic        oe_n_d;
  logic [15:0] rd_q;
  logic [15:0] rd_d;
  logic [4:0]  left_q;
  logic [4:0]  left_d;
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  logic [7:0]  idx_q;
  logic [7:0]  idx_d;
  logic [7:0]  lo_q;
  logic [7:0]  lo_d;
  logic [7:0]  hi_q;
  logic [7:0]  hi_d;
  logic        store_q;
  logic        store_d;
  logic        pass_q;
  logic        pass_d;
  logic        walk_q;
  logic        walk_d;
  logic [TIMER_W-1:0] tmr_q;
  logic [TIMER_W-1:0] tmr_d;

  // ==========================================================
  // array and helpers
  logic [7:0]  mem [MEM_BYTES];
  logic        mem_we;
  logic [7:0]  mem_wa;
  logic [7:0]  mem_wd;
  logic [4:0]  adr_len;
  logic [4:0]  dat_len;
  logic [8:0]  new_adr;
  logic [7:0]  new_base;
  logic [1:0]  sub;
  logic [7:0]  step;
  logic [7:0]  look_ptr;
  logic [15:0] look_word;
  logic [7:0]  store_byte;
  logic        tmr_done;

  // byte index of a word; unused top address bit dropped
  function automatic logic [7:0] base_of(input logic [8:0] a, input logic w16);
    base_of = w16 ? {a[6:0], 1'b0} : a[7:0];  // [RL16]
  endfunction

  // ==========================================================
  // pins pass two flops, third stage only for edges
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {CS, SERIAL_CLOCK_IN, SERIAL_IN, WORD_WIDTH_SELECT};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges and levels from the settled stages
  assign serial_clock_rise = s2_q.serial_clock_in & ~s3_q.serial_clock_in;  // [RL3]
  assign serial_clock_fall = ~s2_q.serial_clock_in & s3_q.serial_clock_in;
  assign cs                = s2_q.cs;
  assign data_bit          = s2_q.serial_in;

  // field widths follow the latched organisation
  assign adr_len = x16_q ? ADR_BITS_X16 : ADR_BITS_X8;  // [RL18]
  assign dat_len = x16_q ? DAT_BITS_X16 : DAT_BITS_X8;  // [RL18]
  assign new_adr  = {adr_q[7:0], data_bit};
  assign new_base = base_of(new_adr, x16_q);
  assign sub      = x16_q ? new_adr[7:6] : new_adr[8:7];
  assign step     = x16_q ? 8'h02 : 8'h01;
  // one lookup serves both the first word and the sequential next one
  assign look_ptr  = (st_q == S_READ) ? 8'(ptr_q + step) : new_base;
  assign look_word = x16_q ? {mem[{look_ptr[7:1], 1'b0}], mem[{look_ptr[7:1], 1'b1}]}
                           : {mem[look_ptr], 8'h00};
  assign store_byte = (x16_q && !idx_q[0]) ? dat_q[15:8] : dat_q[7:0];
  assign tmr_done   = (tmr_q == TIMER_W'(PROG_CYCLES_P - 1));

  // ==========================================================
  // next-state logic
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    op_d     = op_q;
    adr_d    = adr_q;
    dat_d    = dat_q;
    x16_d    = x16_q;
    unlock_d = unlock_q;
    pend_d   = pend_q;
    status_d = status_q;
    dummy_d  = dummy_q;
    out_d    = out_q;
    rd_d     = rd_q;
    left_d   = left_q;
    ptr_d    = ptr_q;
    idx_d    = idx_q;
    lo_d     = lo_q;
    hi_d     = hi_q;
    store_d  = store_q;
    pass_d   = pass_q;
    walk_d   = walk_q;
    tmr_d    = tmr_q;
    mem_we   = 1'b0;
    mem_wa   = idx_q;
    mem_wd   = ERASED_BYTE;

    // status line: a one sampled on a rise releases it at the next fall
    if (status_q && cs && serial_clock_rise && data_bit) begin
      dummy_d = 1'b1;
    end
    if (dummy_q && serial_clock_fall) begin
      dummy_d  = 1'b0;
      status_d = 1'b0;  // [RL6]
    end

    case (st_q)
      S_START: begin
        // leading zeros are ignored until the start bit
        if (cs && serial_clock_rise && data_bit) begin  // [RL1]
          st_d  = S_SHIFT;
          cnt_d = 5'h00;
          x16_d = s2_q.word_width_select;  // [RL18]
        end
      end
      S_SHIFT: begin
        if (!cs) begin
          st_d = S_START;  // [RL23]
        end else if (serial_clock_rise) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q < OPC_BITS) begin
            op_d = {op_q[0], data_bit};
          end else if (cnt_q < OPC_BITS + adr_len) begin
            adr_d = new_adr;
          end else begin
            dat_d = {dat_q[14:0], data_bit};
          end
          // address complete: decide by opcode [RL2]
          if (cnt_q == OPC_BITS + adr_len - 5'h01) begin
            lo_d    = new_base;
            hi_d    = x16_q ? (new_base | 8'h01) : new_base;
            store_d = 1'b0;
            pend_d  = 1'b0;
            case (op_q)
              OPC_READ: begin
                st_d   = S_READ;  // [RL20]
                out_d  = 1'b0;  // [RL8] dummy zero first
                rd_d   = look_word;
                left_d = dat_len;
                ptr_d  = new_base;
              end
              OPC_ERASE: begin
                st_d   = S_DONE;  // [RL19]
                pend_d = unlock_q;  // [RL21]
              end
              OPC_WRITE: begin
                st_d = S_SHIFT;  // [RL20] data follows
              end
              default: begin
                st_d = S_DONE;
                case (sub)
                  SUB_UNLOCK: unlock_d = 1'b1;
                  SUB_LOCK: unlock_d = 1'b0;
                  SUB_CLEAR_ALL: begin
                    pend_d = unlock_q;  // [RL21]
                    lo_d   = 8'h00;
                    hi_d   = LAST_BYTE;
                  end
                  default: st_d = S_SHIFT;
                endcase
              end
            endcase
          end
          // data complete for single and whole-array writes [RL1]
          if (cnt_q == OPC_BITS + adr_len + dat_len - 5'h01) begin
            st_d    = S_DONE;
            pend_d  = unlock_q;  // [RL21]
            store_d = 1'b1;
            if (op_q == OPC_SPECIAL) begin
              lo_d = 8'h00;
              hi_d = LAST_BYTE;
            end
          end
        end
      end
      S_READ: begin
        if (!cs) begin
          st_d = S_START;
        end else if (serial_clock_rise) begin
          // bits change on the rise; sequential read rolls over
          if (left_q == 5'h00) begin
            ptr_d  = look_ptr;
            out_d  = look_word[15];  // [RL9]
            rd_d   = {look_word[14:0], 1'b0};
            left_d = dat_len - 5'h01;
          end else begin
            out_d  = rd_q[15];  // [RL8] [RL9]
            rd_d   = {rd_q[14:0], 1'b0};
            left_d = left_q - 5'h01;
          end
        end
      end
      S_DONE: begin
        // extra clocks ignored; only the select fall acts
        if (!cs) begin
          if (pend_q) begin
            st_d     = S_PROG;  // [RL11] [RL10] [RL14]
            idx_d    = lo_q;
            pass_d   = 1'b0;
            walk_d   = 1'b1;
            tmr_d    = '0;
            status_d = 1'b1;
            dummy_d  = 1'b0;
          end else begin
            st_d = S_START;
          end
        end
      end
      S_PROG: begin
        // self-timed: serial clocks play no part here [RL12]
        if (!tmr_done) begin
          tmr_d = tmr_q + TIMER_W'(1);
        end
        if (walk_q) begin
          mem_we = 1'b1;
          mem_wd = pass_q ? store_byte : ERASED_BYTE;  // [RL13] [RL15]
          if (idx_q == hi_q) begin
            if (!pass_q && store_q) begin
              pass_d = 1'b1;  // [RL11] clear done, now store
              idx_d  = lo_q;
            end else begin
              walk_d = 1'b0;
            end
          end else begin
            idx_d = idx_q + 8'h01;
          end
        end else if (tmr_done) begin
          st_d   = S_START;  // [RL22]
          pend_d = 1'b0;
        end
      end
      default: st_d = S_START;
    endcase

    // outside a read the line shows ready or busy
    if (st_d != S_READ) begin
      out_d = (st_d != S_PROG);  // [RL5]
    end
    oe_n_d = ~(cs && ((st_d == S_READ) || status_d));  // [RL4]
  end

  // ==========================================================
  // registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q     <= S_START;
      cnt_q    <= 5'h00;
      op_q     <= 2'h0;
      adr_q    <= 9'h000;
      dat_q    <= 16'h0000;
      x16_q    <= 1'b1;
      unlock_q <= 1'b0;  // [RL21]
      pend_q   <= 1'b0;
      status_q <= 1'b0;
      dummy_q  <= 1'b0;
      out_q    <= 1'b1;
      oe_n_q   <= 1'b1;
      rd_q     <= 16'h0000;
      left_q   <= 5'h00;
      ptr_q    <= 8'h00;
      idx_q    <= 8'h00;
      lo_q     <= 8'h00;
      hi_q     <= 8'h00;
      store_q  <= 1'b0;
      pass_q   <= 1'b0;
      walk_q   <= 1'b0;
      tmr_q    <= '0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      op_q     <= op_d;
      adr_q    <= adr_d;
      dat_q    <= dat_d;
      x16_q    <= x16_d;
      unlock_q <= unlock_d;
      pend_q   <= pend_d;
      status_q <= status_d;
      dummy_q  <= dummy_d;
      out_q    <= out_d;
      oe_n_q   <= oe_n_d;
      rd_q     <= rd_d;
      left_q   <= left_d;
      ptr_q    <= ptr_d;
      idx_q    <= idx_d;
      lo_q     <= lo_d;
      hi_q     <= hi_d;
      store_q  <= store_d;
      pass_q   <= pass_d;
      walk_q   <= walk_d;
      tmr_q    <= tmr_d;
    end
  end

  // array starts blank so a fresh part reads all ones
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= ERASED_BYTE;  // [RL15]
      end
    end else if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign SERIAL_OUT      = out_q;
  assign SERIAL_OUT_OE_N = oe_n_q;
endmodule
`default_nettype wire

// *** verif/sepc_port_props.sv ***
// pin-level checks of the serial memory command port
`timescale 1ns/100ps
`default_nettype none
module sepc_port_props #(
  parameter int PROG_CYCLES_P = 64
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CS,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_IN,
  input wire logic WORD_WIDTH_SELECT,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE_N
);
  // ==========================================================
  // properties
  // busy bound: timer plus two array passes, with slack
  localparam int MAX_W = PROG_CYCLES_P + 600;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_reset_idle: assert property (
    $rose(RST_N) |-> SERIAL_OUT_OE_N) else $error("output driven after reset");
  chk_float_deselect: assert property (
    !CS [*5] |-> SERIAL_OUT_OE_N) else $error("output driven while deselected");
  chk_release_cs: assert property (
    $fell(CS) |-> ##[3:5] SERIAL_OUT_OE_N) else $error("output not floated after deselect");
  chk_drive_needs_cs: assert property (
    $fell(SERIAL_OUT_OE_N) |-> $past(CS, 3)) else $error("output driven without select");
  chk_release_fall: assert property (
    $rose(SERIAL_OUT_OE_N) && CS |-> !$past(SERIAL_CLOCK_IN, 3))
    else $error("release not on falling clock");
  chk_dummy_zero: assert property (
    $fell(SERIAL_OUT_OE_N) && $past(SERIAL_CLOCK_IN, 3) |-> !SERIAL_OUT)
    else $error("read did not open with zero");
  chk_data_on_rise: assert property (
    $fell(SERIAL_OUT) && !SERIAL_OUT_OE_N |-> $past(SERIAL_CLOCK_IN, 3))
    else $error("read bit changed off rising clock");
  chk_ready_bound: assert property (
    $fell(SERIAL_OUT_OE_N) && !SERIAL_OUT && !$past(SERIAL_CLOCK_IN, 3)
    |-> ##[0:MAX_W] (SERIAL_OUT || SERIAL_OUT_OE_N)) else $error("busy too long");
endmodule
bind sepc_port sepc_port_props #(.PROG_CYCLES_P(PROG_CYCLES_P)) sepc_port_props_inst (
  .CLK(CLK), .RST_N(RST_N), .CS(CS), .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN),
  .SERIAL_IN(SERIAL_IN), .WORD_WIDTH_SELECT(WORD_WIDTH_SELECT),
  .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N));
`default_nettype wire

// *** verif/sepc_host.sv ***
// host model driving select, serial clock and serial input
`timescale 1ns/100ps
`default_nettype none
module sepc_host (
  input  wire logic clk,
  output logic      cs,
  output logic      serial_clock_in,
  output logic      serial_in
);
  // ==========================================================
  // bit pacing
  // six clocks a phase: margin over the three-clock sync path
  localparam int PH = 6;
  initial begin
    cs              = 1'b0;
    serial_clock_in = 1'b0;
    serial_in       = 1'b0;
  end
  // data set a phase ahead of the rise, held a phase after
  task automatic bit1(input logic b);
    serial_in <= b;
    repeat (PH) @(posedge clk);
    serial_clock_in <= 1'b1;
    repeat (PH) @(posedge clk);
    serial_clock_in <= 1'b0;
  endtask
  // whole frame, msb first
  task automatic send(input logic [31:0] v, input int n);
    cs <= 1'b1;
    for (int i = n - 1; i >= 0; i--) bit1(v[i]);
  endtask
  // deselect; line no longer meaningful, so show its inverse
  task automatic stop();
    cs        <= 1'b0;
    serial_in <= ~serial_in;
    repeat (PH) @(posedge clk);
  endtask
  task automatic sel();
    cs <= 1'b1;
    repeat (PH) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** verif/sepc_port_tb_top.sv ***
// self-checking bench for the serial memory command port
`timescale 1ns/100ps
`default_nettype none
module sepc_port_tb_top;
  import sepc_pkg::*;
  // ==========================================================
  // wiring and expected array
  logic        clk;
  logic        rst_n;
  logic        x16_sel;
  logic        cs, serial_clock_in, serial_in, so, so_oe_n;
  logic        unl;
  logic [8:0]  a;
  logic [15:0] d;
  logic [7:0]  mem [256];
  int          err_total;
  int          check_count;
  int          seed;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  sepc_host sepc_host_inst (.clk(clk), .cs(cs), .serial_clock_in(serial_clock_in),
    .serial_in(serial_in));
  sepc_port #(.PROG_CYCLES_P(64)) sepc_port_inst (.CLK(clk), .RST_N(rst_n), .CS(cs),
    .SERIAL_CLOCK_IN(serial_clock_in), .SERIAL_IN(serial_in), .WORD_WIDTH_SELECT(x16_sel),
    .SERIAL_OUT(so), .SERIAL_OUT_OE_N(so_oe_n));
  // verdict and comparisons
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: pin %b want %b", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask
  // x16 word a is bytes 2a (high) and 2a+1; top address bit ignored
  function automatic logic [15:0] exp_rd(input logic w, input logic [8:0] ad);
    return w ? {mem[{ad[6:0], 1'b0}], mem[{ad[6:0], 1'b1}]} : {8'h00, mem[ad[7:0]]};
  endfunction
  task automatic put(input logic w, input logic [8:0] ad, input logic [15:0] v);
    if (w) {mem[{ad[6:0], 1'b0}], mem[{ad[6:0], 1'b1}]} = v;
    else mem[ad[7:0]] = v[7:0];
  endtask
  // status poll, then dummy one so a shared data line is free again
  task automatic poll();
    int n;
    sepc_host_inst.sel();
    cmp_bit(so_oe_n, 1'b0);
    cmp_bit(so, 1'b0);
    n = 0;
    while (so !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n == 1000) begin
      err_total++;
      $display("unexpected at %0t: status stuck busy", $time);
      give_verdict();
    end
    cmp_bit(so, 1'b1);
    sepc_host_inst.bit1(1'b1);
    repeat (6) @(posedge clk);
    cmp_bit(so_oe_n, 1'b1);
    sepc_host_inst.stop();
  endtask
  task automatic run(input logic w, input logic [31:0] v, input int n, input logic p);
    x16_sel <= w;
    sepc_host_inst.send(v, n);
    sepc_host_inst.stop();
    if (p) poll();
  endtask
  task automatic wr(input logic w, input logic [8:0] ad, input logic [15:0] v);
    if (w) run(w, 32'({1'b1, OPC_WRITE, ad[7:0], v}), 27, unl);
    else run(w, 32'({1'b1, OPC_WRITE, ad, v[7:0]}), 20, unl);
    if (unl) put(w, ad, v);
  endtask
  task automatic rd(input logic w, input logic [8:0] ad);
    logic [15:0] got;
    logic [15:0] nxt;
    got = '0;
    nxt = '0;
    x16_sel <= w;
    if (w) sepc_host_inst.send(32'({1'b1, OPC_READ, ad[7:0]}), 11);
    else sepc_host_inst.send(32'({1'b1, OPC_READ, ad}), 12);
    cmp_bit(so_oe_n, 1'b0);
    cmp_bit(so, 1'b0);
    for (int i = 0; i < (w ? 16 : 8); i++) begin
      sepc_host_inst.bit1(1'b0);
      got = {got[14:0], so};
    end
    // sequential read runs on into the next word with no dummy bit
    for (int i = 0; i < (w ? 16 : 8); i++) begin
      sepc_host_inst.bit1(1'b0);
      nxt = {nxt[14:0], so};
    end
    sepc_host_inst.stop();
    cmp_word(got, exp_rd(w, ad));
    cmp_word(nxt, exp_rd(w, 9'(ad + 9'h001)));
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    $display("unexpected at %0t: run hung", $time);
    give_verdict();
  end
  // main sequence: locked, write pairs, erase, abort, array ops, lock
  initial begin
    seed = 32'h86ea;
    err_total = 0;
    check_count = 0;
    unl = 1'b0;
    rst_n = 1'b0;
    x16_sel = 1'b1;
    for (int j = 0; j < 256; j++) mem[j] = ERASED_BYTE;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cmp_bit(so_oe_n, 1'b1);
    a = 9'($random(seed));
    d = 16'($random(seed));
    wr(1'b1, a, d);
    sepc_host_inst.sel();
    cmp_bit(so_oe_n, 1'b1);
    sepc_host_inst.stop();
    rd(1'b1, a);
    run(1'b1, 32'({1'b1, OPC_SPECIAL, SUB_UNLOCK, 6'h00}), 11, 1'b0);
    unl = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = 9'($random(seed));
      d = 16'($random(seed));
      wr(i[0], a, d);
      wr(i[0], a, ~d);
      rd(i[0], a);
      if (i[0]) run(1'b1, 32'({1'b1, OPC_ERASE, a[7:0]}), 11, 1'b1);
      else run(1'b0, 32'({1'b1, OPC_ERASE, a}), 12, 1'b1);
      put(i[0], a, 16'hFFFF);
      rd(i[0], a);
    end
    run(1'b1, 32'({1'b1, OPC_WRITE, a[7:0], d[15:8]}), 19, 1'b0);
    rd(1'b1, a);
    run(1'b1, 32'({1'b1, OPC_SPECIAL, SUB_FILL_ALL, 6'h00, d}), 27, 1'b1);
    for (int j = 0; j < 256; j++) mem[j] = j[0] ? d[7:0] : d[15:8];
    rd(1'b0, a);
    run(1'b1, 32'({1'b1, OPC_SPECIAL, SUB_CLEAR_ALL, 6'h00}), 11, 1'b1);
    for (int j = 0; j < 256; j++) mem[j] = ERASED_BYTE;
    run(1'b1, 32'({1'b1, OPC_SPECIAL, SUB_LOCK, 6'h00}), 11, 1'b0);
    unl = 1'b0;
    wr(1'b0, a, d);
    rd(1'b0, a);
    give_verdict();
  end
endmodule
`default_nettype wire
